// ===== core/cmt_consts.vh
/*
  Constants of the compare timer: register offsets on the 8-bit peripheral
  bus, field positions, reset values, power-mode codes and count-clock
  dividers. Assumes it is included by its bare name from the core files.
*/
`ifndef CMT_CONSTS_VH
`define CMT_CONSTS_VH

// Register offsets on the 3-bit byte address
`define CMT_OFF_COUNT_HI    3'h0
`define CMT_OFF_COUNT_LO    3'h1
`define CMT_OFF_COMPARE_HI  3'h2
`define CMT_OFF_COMPARE_LO  3'h3
`define CMT_OFF_CTRL        3'h4
`define CMT_OFF_CTRL_STATUS 3'h5
`define CMT_OFF_CLK_STOP    3'h6

// Reset values
`define CMT_RST_COUNT       16'h0000
`define CMT_RST_COMPARE     16'hffff
`define CMT_RST_CTRL        8'h00
`define CMT_RST_STATUS      8'h00
`define CMT_RST_CLK_STOP    8'hff
`define CMT_UNMAPPED_READ   8'hff

// Timer control fields
`define CMT_CTRL_OUT_LEVEL_HI 7
`define CMT_CTRL_SEL_HI_MSB   6
`define CMT_CTRL_SEL_HI_LSB   4
`define CMT_CTRL_OUT_LEVEL_LO 3
`define CMT_CTRL_SEL_LO_MSB   2
`define CMT_CTRL_SEL_LO_LSB   0

// Timer control/status fields
`define CMT_ST_WRAP_FLAG_HI   7
`define CMT_ST_MATCH_FLAG_HI  6
`define CMT_ST_WRAP_IRQ_EN_HI 5
`define CMT_ST_CLEAR_HI       4
`define CMT_ST_WRAP_FLAG_LO   3
`define CMT_ST_MATCH_FLAG_LO  2
`define CMT_ST_WRAP_IRQ_EN_LO 1
`define CMT_ST_CLEAR_LO       0
`define CMT_ST_FLAG_MASK      8'hcc

// Clock stop register: module run bit and the two bits that read as one
`define CMT_STOP_RUN_BIT      2
`define CMT_STOP_FIXED_ONES   8'hc0

// Power modes of the surrounding chip
`define CMT_MODE_ACTIVE       3'h0
`define CMT_MODE_SLEEP        3'h1
`define CMT_MODE_WATCH        3'h2
`define CMT_MODE_SUBACTIVE    3'h3
`define CMT_MODE_SUBSLEEP     3'h4
`define CMT_MODE_STANDBY      3'h5

// Count-clock selections (low two bits of a clock-select field)
`define CMT_SEL_DIV32         2'h0
`define CMT_SEL_DIV16         2'h1
`define CMT_SEL_DIV4          2'h2
`define CMT_SEL_WATCH4        2'h3

// Prescaler terminal counts
`define CMT_PRE_DIV32_END     5'h1f
`define CMT_PRE_DIV16_END     4'hf
`define CMT_PRE_DIV4_END      2'h3
`define CMT_WATCH_DIV4_END    2'h3

`endif

// ===== core/cmt_edge_det.v
/*
  Two-flop synchroniser with rise and fall pulse outputs.
  Assumes the input level holds for at least two clock periods so that
  every change is seen.
*/
`timescale 1ns/100ps
`default_nettype none

module cmt_edge_det (
  // Clock and reset
  input  wire ref_clk,
  input  wire sys_rst,
  // Level in, edge pulses out
  input  wire level_in,
  output reg  rise_r,
  output reg  fall_r
);

  reg meta_r;
  reg sync_r;
  reg last_r;

  // The first stage feeds only the second; edges are taken after it
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
      last_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      meta_r <= level_in;
      sync_r <= meta_r;
      last_r <= sync_r;
      rise_r <= sync_r & ~last_r;
      fall_r <= ~sync_r & last_r;
    end
  end

endmodule // cmt_edge_det

`default_nettype wire

// ===== core/cmt_timer.v
/*
  Compare timer: one 16-bit up-counter or two 8-bit counters, each with a
  compare byte, clear on match, flags, interrupt requests and a toggling pin.
  Assumes an 8-bit CPU bus with one-cycle read and write strobes, interrupt
  enables and edge select from the interrupt controller, and a power-mode
  code from the system controller. The watch clock is a slow level sampled
  here.

// Summary of operation
// - Low clear-on-match bit set clears the low counter on its match; reset zero.
// - Module run bit zero stops the timer; it resets to one.
// - In 8-bit mode byte accesses work in any order.
// - Upper-byte write fills the latch; lower-byte write commits both bytes.
// - Counter upper read latches the lower byte; lower read returns the latch.
// - Compare reads return register bytes directly.
// - High select MSB zero gives 16-bit mode; one splits into two 8-bit counters.
// - Reset: counter zero, compare all ones, control and status zero.
// - 16-bit match sets high flag, toggles high pin, requests, optionally clears.
// - 16-bit wrap sets high wrap flag; request needs both enables.
// - Each 8-bit half matches independently with flag, toggle, request, clear.
// - Each 8-bit half wrap sets its flag; request needs both enables.
// - Select fields choose system clock /32, /16, /4 or watch clock /4.
// - Low select MSB zero counts external event edges chosen by edge select.
// - Each pin drives its written level and inverts on each match.
// - Match fires when the counter leaves the matching value.
// - Counting per power mode; halted in standby and module standby.
// - Watch clock passes a synchroniser; one-period count error tolerated.
// - Flags set by hardware only; cleared by read-one then write-zero.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cmt_consts.vh"

module cmt_timer (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       sys_rst,
  // CPU byte bus
  input  wire [2:0] bus_addr,
  input  wire       bus_wr,
  input  wire       bus_rd,
  input  wire [7:0] bus_wdata,
  output reg  [7:0] bus_rdata_r,
  // System state and interrupt controller settings
  input  wire [2:0] power_mode,
  input  wire       timer_irq_en_hi,
  input  wire       timer_irq_en_lo,
  input  wire       event_edge_sel,
  // Count sources
  input  wire       watch_clk_in,
  input  wire       event_in_pin,
  // Pins and interrupt requests
  output reg        toggle_pin_hi_r,
  output reg        toggle_pin_lo_r,
  output reg        irq_req_hi_r,
  output reg        irq_req_lo_r
);

  // One-hot state of the read/write byte latch
  localparam [1:0] TMP_IDLE = 2'b01;
  localparam [1:0] TMP_HELD = 2'b10;

  reg [15:0] count_reg_r;
  reg [15:0] count_reg_nxt;
  reg [15:0] compare_reg_r;
  reg [7:0]  timer_ctrl_r;
  reg [7:0]  timer_ctrl_status_r;
  reg [7:0]  status_nxt;
  reg [7:0]  clk_stop_r;
  reg [7:0]  temp_r;
  reg [1:0]  tmp_state_r;
  reg [3:0]  clear_armed_r;
  reg [4:0]  pre_r;
  reg [1:0]  wdiv_r;
  reg [7:0]  rdata_nxt;

  wire watch_rise;
  wire event_rise;
  wire event_fall;

  // Function that picks an internal count tick from a two-bit selection
  function src_tick;
    input [1:0] sel;
    input       t32;
    input       t16;
    input       t4;
    input       tw4;
    begin
      case (sel)
        `CMT_SEL_DIV32: src_tick = t32;
        `CMT_SEL_DIV16: src_tick = t16;
        `CMT_SEL_DIV4:  src_tick = t4;
        default:        src_tick = tw4;
      endcase
    end
  endfunction

  // Function that says whether a source may count in the given power mode
  function run_ok;
    input [2:0] mode;
    input       is_watch;
    begin
      if ((mode == `CMT_MODE_ACTIVE) || (mode == `CMT_MODE_SLEEP))
        run_ok = 1'b1;
      else if ((mode == `CMT_MODE_WATCH) || (mode == `CMT_MODE_SUBACTIVE) || (mode == `CMT_MODE_SUBSLEEP))
        run_ok = is_watch;
      else
        run_ok = 1'b0;
    end
  endfunction

  // Watch clock and event pin both pass a synchroniser
  cmt_edge_det u_watch_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .level_in (watch_clk_in),
    .rise_r   (watch_rise),
    .fall_r   ()
  );

  cmt_edge_det u_event_sync (
    .ref_clk  (ref_clk),
    .sys_rst  (sys_rst),
    .level_in (event_in_pin),
    .rise_r   (event_rise),
    .fall_r   (event_fall)
  );

  // Field views
  wire       split_mode  = timer_ctrl_r[`CMT_CTRL_SEL_HI_MSB];
  wire [1:0] sel_hi      = timer_ctrl_r[`CMT_CTRL_SEL_HI_LSB+1:`CMT_CTRL_SEL_HI_LSB];
  wire [1:0] sel_lo      = timer_ctrl_r[`CMT_CTRL_SEL_LO_LSB+1:`CMT_CTRL_SEL_LO_LSB];
  wire       ext_lo      = ~timer_ctrl_r[`CMT_CTRL_SEL_LO_MSB];
  wire       module_run  = clk_stop_r[`CMT_STOP_RUN_BIT];
  wire       clr_hi      = timer_ctrl_status_r[`CMT_ST_CLEAR_HI];
  wire       clr_lo      = timer_ctrl_status_r[`CMT_ST_CLEAR_LO];
  wire       wrap_en_hi  = timer_ctrl_status_r[`CMT_ST_WRAP_IRQ_EN_HI];
  wire       wrap_en_lo  = timer_ctrl_status_r[`CMT_ST_WRAP_IRQ_EN_LO];

  // Bus strobes; writes are refused outside active and subactive
  wire wr_ok = bus_wr & ((power_mode == `CMT_MODE_ACTIVE) || (power_mode == `CMT_MODE_SUBACTIVE));
  wire wr_cnt_hi = wr_ok & (bus_addr == `CMT_OFF_COUNT_HI);
  wire wr_cnt_lo = wr_ok & (bus_addr == `CMT_OFF_COUNT_LO);
  wire wr_cmp_hi = wr_ok & (bus_addr == `CMT_OFF_COMPARE_HI);
  wire wr_cmp_lo = wr_ok & (bus_addr == `CMT_OFF_COMPARE_LO);
  wire wr_ctrl   = wr_ok & (bus_addr == `CMT_OFF_CTRL);
  wire wr_status = wr_ok & (bus_addr == `CMT_OFF_CTRL_STATUS);
  wire wr_stop   = wr_ok & (bus_addr == `CMT_OFF_CLK_STOP);
  wire rd_cnt_hi = bus_rd & (bus_addr == `CMT_OFF_COUNT_HI);
  wire rd_status = bus_rd & (bus_addr == `CMT_OFF_CTRL_STATUS);

  // In 16-bit mode upper-byte writes only load the latch
  wire cnt_hi_direct = wr_cnt_hi & split_mode;
  wire cnt_lo_commit = wr_cnt_lo;
  wire cmp_hi_direct = wr_cmp_hi & split_mode;

  // Prescaler ticks: system clock /32, /16, /4 and watch clock /4
  wire t32 = (pre_r == `CMT_PRE_DIV32_END);
  wire t16 = (pre_r[3:0] == `CMT_PRE_DIV16_END);
  wire t4  = (pre_r[1:0] == `CMT_PRE_DIV4_END);
  wire tw4 = watch_rise & (wdiv_r == `CMT_WATCH_DIV4_END);

  // Low tick: external event edge or internal source
  wire ev_tick   = event_edge_sel ? event_rise : event_fall;
  wire raw_lo    = ext_lo ? ev_tick : src_tick(sel_lo, t32, t16, t4, tw4);
  wire lo_watch  = ~ext_lo & (sel_lo == `CMT_SEL_WATCH4);
  wire tick_lo   = raw_lo & module_run & run_ok(power_mode, lo_watch);
  // High tick: shares the low tick in 16-bit mode
  wire raw_hi    = src_tick(sel_hi, t32, t16, t4, tw4);
  wire hi_watch  = (sel_hi == `CMT_SEL_WATCH4);
  wire tick_hi8  = raw_hi & module_run & run_ok(power_mode, hi_watch);
  wire tick_hi   = split_mode ? tick_hi8 : tick_lo;

  // Matches fire on the tick that leaves the equal value; a compare write in that cycle voids them
  wire eq_lo     = (count_reg_r[7:0] == compare_reg_r[7:0]);
  wire eq_hi     = (count_reg_r[15:8] == compare_reg_r[15:8]);
  wire match_lo  = tick_lo & eq_lo & ~wr_cmp_lo;
  wire match_h8  = tick_hi8 & eq_hi & ~cmp_hi_direct;
  wire match_16  = tick_lo & eq_lo & eq_hi & ~wr_cmp_lo;
  wire match_hi  = split_mode ? match_h8 : match_16;
  // Wraps; a counter write in the same cycle suppresses the event
  wire wrap_lo   = tick_lo & (count_reg_r[7:0] == 8'hff) & ~cnt_lo_commit;
  wire wrap_h8   = tick_hi8 & (count_reg_r[15:8] == 8'hff) & ~cnt_hi_direct;
  wire wrap_16   = tick_lo & (count_reg_r == 16'hffff) & ~cnt_lo_commit;
  wire wrap_hi   = split_mode ? wrap_h8 : wrap_16;

  // Counter next value
  always @* begin
    count_reg_nxt = count_reg_r;
    if (split_mode) begin
      if (match_lo && clr_lo)
        count_reg_nxt[7:0] = 8'h00;
      else if (tick_lo)
        count_reg_nxt[7:0] = count_reg_r[7:0] + 8'h01;
      if (match_h8 && clr_hi)
        count_reg_nxt[15:8] = 8'h00;
      else if (tick_hi)
        count_reg_nxt[15:8] = count_reg_r[15:8] + 8'h01;
      if (cnt_hi_direct)
        count_reg_nxt[15:8] = bus_wdata;
      if (cnt_lo_commit)
        count_reg_nxt[7:0] = bus_wdata;
    end else begin
      if (match_16 && clr_hi)
        count_reg_nxt = 16'h0000;
      else if (tick_lo)
        count_reg_nxt = count_reg_r + 16'h0001;
      if (cnt_lo_commit)
        count_reg_nxt = {temp_r, bus_wdata};
    end
  end

  // Status next value: hardware sets win over a software clear in the same cycle
  always @* begin
    status_nxt = timer_ctrl_status_r;
    if (wr_status) begin
      status_nxt = (timer_ctrl_status_r & `CMT_ST_FLAG_MASK) | (bus_wdata & ~`CMT_ST_FLAG_MASK);
      // Flags clear only on a zero written after they were read as one
      if (clear_armed_r[3] && !bus_wdata[`CMT_ST_WRAP_FLAG_HI])
        status_nxt[`CMT_ST_WRAP_FLAG_HI] = 1'b0;
      if (clear_armed_r[2] && !bus_wdata[`CMT_ST_MATCH_FLAG_HI])
        status_nxt[`CMT_ST_MATCH_FLAG_HI] = 1'b0;
      if (clear_armed_r[1] && !bus_wdata[`CMT_ST_WRAP_FLAG_LO])
        status_nxt[`CMT_ST_WRAP_FLAG_LO] = 1'b0;
      if (clear_armed_r[0] && !bus_wdata[`CMT_ST_MATCH_FLAG_LO])
        status_nxt[`CMT_ST_MATCH_FLAG_LO] = 1'b0;
    end
    if (wrap_hi)
      status_nxt[`CMT_ST_WRAP_FLAG_HI] = 1'b1;
    if (match_hi)
      status_nxt[`CMT_ST_MATCH_FLAG_HI] = 1'b1;
    if (wrap_lo)
      status_nxt[`CMT_ST_WRAP_FLAG_LO] = 1'b1;
    if (match_lo)
      status_nxt[`CMT_ST_MATCH_FLAG_LO] = 1'b1;
  end

  // Read data decode
  always @* begin
    if (bus_addr == `CMT_OFF_COUNT_HI)
      rdata_nxt = count_reg_r[15:8];
    else if (bus_addr == `CMT_OFF_COUNT_LO)
      rdata_nxt = (!split_mode && tmp_state_r == TMP_HELD) ? temp_r : count_reg_r[7:0];
    else if (bus_addr == `CMT_OFF_COMPARE_HI)
      rdata_nxt = compare_reg_r[15:8];
    else if (bus_addr == `CMT_OFF_COMPARE_LO)
      rdata_nxt = compare_reg_r[7:0];
    else if (bus_addr == `CMT_OFF_CTRL)
      rdata_nxt = timer_ctrl_r;
    else if (bus_addr == `CMT_OFF_CTRL_STATUS)
      rdata_nxt = timer_ctrl_status_r;
    else if (bus_addr == `CMT_OFF_CLK_STOP)
      rdata_nxt = clk_stop_r | `CMT_STOP_FIXED_ONES;
    else
      rdata_nxt = `CMT_UNMAPPED_READ;
  end

  // Prescaler and watch divider run whenever the module runs
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r  <= 5'h00;
      wdiv_r <= 2'h0;
    end else begin
      if (module_run) begin
        pre_r <= pre_r + 5'h01;
        if (watch_rise)
          wdiv_r <= wdiv_r + 2'h1;
      end
    end
  end

  // Byte latch: upper writes and upper counter reads fill it in 16-bit mode
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      temp_r      <= 8'h00;
      tmp_state_r <= TMP_IDLE;
    end else begin
      case (tmp_state_r)
        TMP_IDLE: begin
          if (!split_mode && (wr_cnt_hi || wr_cmp_hi)) begin
            temp_r      <= bus_wdata;
            tmp_state_r <= TMP_HELD;
          end else if (!split_mode && rd_cnt_hi) begin
            temp_r      <= count_reg_r[7:0];
            tmp_state_r <= TMP_HELD;
          end
        end
        TMP_HELD: begin
          // Software must follow an upper access with the lower one; a stray access reloads
          if (!split_mode && (wr_cnt_hi || wr_cmp_hi))
            temp_r <= bus_wdata;
          else if (!split_mode && rd_cnt_hi)
            temp_r <= count_reg_r[7:0];
          else if (wr_cnt_lo || wr_cmp_lo || (bus_rd && bus_addr == `CMT_OFF_COUNT_LO))
            tmp_state_r <= TMP_IDLE;
        end
        default: tmp_state_r <= TMP_IDLE;
      endcase
    end
  end

  // Registers
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_reg_r         <= `CMT_RST_COUNT;
      compare_reg_r       <= `CMT_RST_COMPARE;
      timer_ctrl_r        <= `CMT_RST_CTRL;
      timer_ctrl_status_r <= `CMT_RST_STATUS;
      clk_stop_r          <= `CMT_RST_CLK_STOP;
      clear_armed_r       <= 4'h0;
      bus_rdata_r         <= 8'h00;
    end else begin
      count_reg_r         <= count_reg_nxt;
      timer_ctrl_status_r <= status_nxt;
      if (cmp_hi_direct)
        compare_reg_r[15:8] <= bus_wdata;
      if (wr_cmp_lo)
        compare_reg_r <= split_mode ? {compare_reg_r[15:8], bus_wdata} : {temp_r, bus_wdata};
      if (wr_ctrl)
        timer_ctrl_r <= bus_wdata;
      if (wr_stop)
        clk_stop_r <= bus_wdata | `CMT_STOP_FIXED_ONES;
      // Arming follows the last status read; any status write disarms
      if (rd_status)
        clear_armed_r <= {timer_ctrl_status_r[`CMT_ST_WRAP_FLAG_HI], timer_ctrl_status_r[`CMT_ST_MATCH_FLAG_HI],
                          timer_ctrl_status_r[`CMT_ST_WRAP_FLAG_LO], timer_ctrl_status_r[`CMT_ST_MATCH_FLAG_LO]};
      else if (wr_status)
        clear_armed_r <= 4'h0;
      if (bus_rd)
        bus_rdata_r <= rdata_nxt;
    end
  end

  // Output pins: a control write sets the level and wins over a same-cycle match
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      toggle_pin_hi_r <= 1'b0;
      toggle_pin_lo_r <= 1'b0;
    end else begin
      if (wr_ctrl)
        toggle_pin_hi_r <= bus_wdata[`CMT_CTRL_OUT_LEVEL_HI];
      else if (match_hi)
        toggle_pin_hi_r <= ~toggle_pin_hi_r;
      if (wr_ctrl)
        toggle_pin_lo_r <= bus_wdata[`CMT_CTRL_OUT_LEVEL_LO];
      else if (match_lo)
        toggle_pin_lo_r <= ~toggle_pin_lo_r;
    end
  end

  // Interrupt requests, one cycle per event; the low request exists only in 8-bit mode
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_req_hi_r <= 1'b0;
      irq_req_lo_r <= 1'b0;
    end else begin
      irq_req_hi_r <= timer_irq_en_hi & (match_hi | (wrap_hi & wrap_en_hi));
      irq_req_lo_r <= split_mode & timer_irq_en_lo & (match_lo | (wrap_lo & wrap_en_lo));
    end
  end

endmodule // cmt_timer

`default_nettype wire

// ===== sim/cmt_cpu_model.sv
/*
  CPU side of the 8-bit peripheral bus: byte and two-byte access tasks.
  Assumes one-cycle strobes taken at the rising edge, read data one edge later.
*/
`timescale 1ns/100ps
`default_nettype none

module cmt_cpu_model (
  // Clock
  input  wire logic       ref_clk,
  // Byte bus
  output var  logic [2:0] bus_addr,
  output var  logic       bus_wr,
  output var  logic       bus_rd,
  output var  logic [7:0] bus_wdata,
  input  wire logic [7:0] bus_rdata_r
);
  initial begin
    bus_addr = 3'h7;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    bus_wdata = 8'h00;
  end

  // Idle bus shows inverted values so a stale copy is never mistaken for data
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    bus_wr = 1'b0;
    bus_addr = ~a;
    bus_wdata = ~d;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    #1;
    bus_addr = a;
    bus_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    d = bus_rdata_r;
    bus_rd = 1'b0;
    bus_addr = ~a;
  endtask

  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr(a, v[15:8]);
    wr(a + 3'h1, v[7:0]);
  endtask

  task automatic rd16(input logic [2:0] a, output logic [15:0] v);
    rd(a, v[15:8]);
    rd(a + 3'h1, v[7:0]);
  endtask
endmodule // cmt_cpu_model
`default_nettype wire

// ===== sim/cmt_timer_checker.sv
/*
  Port-level assertions for the compare timer.
  Assumes it is bound to cmt_timer and that cmt_consts.vh is on the include path.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cmt_consts.vh"

module cmt_timer_checker (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       sys_rst,
  // Bus and system settings
  input wire logic [2:0] bus_addr,
  input wire logic       bus_wr,
  input wire logic       bus_rd,
  input wire logic [7:0] bus_wdata,
  input wire logic [7:0] bus_rdata_r,
  input wire logic [2:0] power_mode,
  input wire logic       timer_irq_en_hi,
  input wire logic       timer_irq_en_lo,
  // Pins and requests
  input wire logic       toggle_pin_hi_r,
  input wire logic       toggle_pin_lo_r,
  input wire logic       irq_req_hi_r,
  input wire logic       irq_req_lo_r
);
  // Control writes count only in the two modes that service writes
  wire logic ctrl_wr = bus_wr && bus_addr == `CMT_OFF_CTRL &&
                       (power_mode == `CMT_MODE_ACTIVE || power_mode == `CMT_MODE_SUBACTIVE);

  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_reset_quiet: assert property ($fell(sys_rst) |-> !toggle_pin_hi_r && !toggle_pin_lo_r &&
    !irq_req_hi_r && !irq_req_lo_r && bus_rdata_r == 8'h00) else $error("outputs not idle after reset");
  a_irq_hi_pulse: assert property (irq_req_hi_r |=> !irq_req_hi_r)
    else $error("high request longer than one cycle");
  a_irq_hi_enable: assert property (irq_req_hi_r |-> $past(timer_irq_en_hi))
    else $error("high request without enable");
  a_irq_lo_enable: assert property (irq_req_lo_r |-> $past(timer_irq_en_lo))
    else $error("low request without enable");
  a_pin_follows_ctrl: assert property (ctrl_wr |=> toggle_pin_hi_r == $past(bus_wdata[7]) &&
    toggle_pin_lo_r == $past(bus_wdata[3])) else $error("pin level differs from control write");
  a_toggle_with_irq: assert property ($changed(toggle_pin_hi_r) && !$past(ctrl_wr) &&
    $past(timer_irq_en_hi) |-> irq_req_hi_r) else $error("high pin toggled without a request");
  a_stop_fixed_ones: assert property (bus_rd && bus_addr == `CMT_OFF_CLK_STOP |=>
    bus_rdata_r[7:6] == 2'b11) else $error("clock stop upper bits not one");
  a_standby_no_irq: assert property ((power_mode == `CMT_MODE_STANDBY)[*2] |->
    !irq_req_hi_r && !irq_req_lo_r) else $error("request raised in standby");
  a_standby_no_write: assert property ((power_mode == `CMT_MODE_STANDBY)[*2] ##0 bus_wr |=>
    $stable(toggle_pin_hi_r) && $stable(toggle_pin_lo_r)) else $error("write serviced in standby");
endmodule // cmt_timer_checker

bind cmt_timer cmt_timer_checker cmt_timer_checker_inst (.ref_clk, .sys_rst, .bus_addr, .bus_wr, .bus_rd,
  .bus_wdata, .bus_rdata_r, .power_mode, .timer_irq_en_hi, .timer_irq_en_lo, .toggle_pin_hi_r,
  .toggle_pin_lo_r, .irq_req_hi_r, .irq_req_lo_r);
`default_nettype wire

// ===== sim/testbench.sv
/*
  Self-checking testbench of the compare timer with a CPU bus model.
  Assumes cmt_consts.vh offsets, a watch clock of eight system periods.
*/
`timescale 1ns/100ps
`default_nettype none
`include "cmt_consts.vh"

module testbench;
  localparam logic [2:0] cnt_hi = `CMT_OFF_COUNT_HI;
  localparam logic [2:0] cnt_lo = `CMT_OFF_COUNT_LO;
  localparam logic [2:0] cmp_hi = `CMT_OFF_COMPARE_HI;
  localparam logic [2:0] cmp_lo = `CMT_OFF_COMPARE_LO;
  localparam logic [2:0] ctl    = `CMT_OFF_CTRL;
  localparam logic [2:0] sts    = `CMT_OFF_CTRL_STATUS;
  localparam logic [2:0] stp    = `CMT_OFF_CLK_STOP;
  logic       ref_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [2:0] power_mode = `CMT_MODE_ACTIVE;
  logic       event_edge_sel = 1'b1;
  logic       watch_clk_in = 1'b0;
  logic       event_in_pin = 1'b0;
  logic       irq_en_hi = 1'b1;
  wire  logic [2:0] bus_addr;
  wire  logic       bus_wr;
  wire  logic       bus_rd;
  wire  logic [7:0] bus_wdata;
  wire  logic [7:0] bus_rdata_r;
  wire  logic       toggle_pin_hi_r;
  wire  logic       toggle_pin_lo_r;
  wire  logic       irq_req_hi_r;
  wire  logic       irq_req_lo_r;
  int         fail_count = 0;
  int         checks_done = 0;
  int         irq_hi_seen = 0;
  int         irq_lo_seen = 0;
  logic [7:0] rv;
  logic [15:0] v16;
  logic [15:0] rnd;
  // Model tables: reset image of offsets 0..7, then rate cases
  logic [7:0] rst_tab[8] = '{8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
  int sel_t[8]  = '{0, 1, 2, 3, 2, 3, 3, 2};
  int mode_t[8] = '{0, 0, 0, 0, 2, 4, 5, 0};
  int stop_t[8] = '{255, 255, 255, 255, 255, 255, 255, 251};
  int exp_t[8]  = '{8, 16, 64, 8, 0, 8, 0, 0};

  always #4 ref_clk = ~ref_clk;
  always #32 watch_clk_in = ~watch_clk_in;

  always @(posedge ref_clk) begin
    if (irq_req_hi_r === 1'b1)
      irq_hi_seen++;
    if (irq_req_lo_r === 1'b1)
      irq_lo_seen++;
  end

  cmt_cpu_model cmt_cpu_model_inst (.ref_clk(ref_clk), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata_r(bus_rdata_r));

  cmt_timer cmt_timer_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .bus_addr(bus_addr), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata_r(bus_rdata_r), .power_mode(power_mode),
    .timer_irq_en_hi(irq_en_hi), .timer_irq_en_lo(1'b1), .event_edge_sel(event_edge_sel),
    .watch_clk_in(watch_clk_in), .event_in_pin(event_in_pin), .toggle_pin_hi_r(toggle_pin_hi_r),
    .toggle_pin_lo_r(toggle_pin_lo_r), .irq_req_hi_r(irq_req_hi_r), .irq_req_lo_r(irq_req_lo_r));

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    checks_done++;
    if (got !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] e, input string what);
    cmt_cpu_model_inst.rd(a, rv);
    chk(what, {8'h00, e}, {8'h00, rv});
  endtask

  // Each level is held six clocks, well above the two-clock minimum
  task automatic pulse();
    event_in_pin = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1 event_in_pin = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask

  task automatic final_report();
    $display("counts: %0d checks, %0d mismatches", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #160000;
    fail_count++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    final_report();
  end

  initial begin
    rnd = 16'($urandom(32'h5681));
    repeat (16) @(posedge ref_clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 8; i++)
      rdc(i[2:0], rst_tab[i], "reset image");
    $display("test reset image done");

    rnd = 16'($urandom);
    v16 = {rnd[15:9], 1'b0, 8'hff};
    cmt_cpu_model_inst.wr16(cnt_hi, v16);
    rdc(cnt_hi, v16[15:8], "count hi");
    pulse();
    rdc(cnt_lo, 8'hff, "latched count lo");
    event_edge_sel = 1'b0;
    pulse();
    cmt_cpu_model_inst.rd16(cnt_hi, rnd);
    chk("event count", v16 + 16'h0002, rnd);
    v16 = 16'($urandom);
    cmt_cpu_model_inst.wr16(cmp_hi, v16);
    rdc(cmp_lo, v16[7:0], "compare lo");
    rdc(cmp_hi, v16[15:8], "compare hi");
    $display("test byte latch done");

    cmt_cpu_model_inst.wr(ctl, 8'h80);
    chk("pin hi level", 16'h1, {15'h0, toggle_pin_hi_r});
    cmt_cpu_model_inst.wr16(cmp_hi, 16'h0003);
    cmt_cpu_model_inst.wr16(cnt_hi, 16'h0001);
    cmt_cpu_model_inst.rd(sts, rv);
    cmt_cpu_model_inst.wr(sts, 8'h10);
    irq_hi_seen = 0;
    pulse();
    pulse();
    chk("irq at first equality", 16'h0, irq_hi_seen[15:0]);
    pulse();
    chk("irq after match", 16'h1, irq_hi_seen[15:0]);
    chk("pin hi toggled", 16'h0, {15'h0, toggle_pin_hi_r});
    cmt_cpu_model_inst.rd16(cnt_hi, rnd);
    chk("cleared count", 16'h0000, rnd);
    rdc(sts, 8'h54, "match flags");
    cmt_cpu_model_inst.wr(sts, 8'hdc);
    rdc(sts, 8'h54, "flags after ones");
    cmt_cpu_model_inst.wr(sts, 8'h10);
    rdc(sts, 8'h10, "flags after zeros");
    irq_en_hi = 1'b0;
    irq_hi_seen = 0;
    repeat (4) pulse();
    chk("irq when disabled", 16'h0, irq_hi_seen[15:0]);
    rdc(sts, 8'h54, "flags when disabled");
    irq_en_hi = 1'b1;
    $display("test sixteen bit match done");

    cmt_cpu_model_inst.wr16(cnt_hi, 16'hfefd);
    cmt_cpu_model_inst.wr16(cmp_hi, 16'h10fe);
    cmt_cpu_model_inst.wr(sts, 8'h21);
    irq_hi_seen = 0;
    irq_lo_seen = 0;
    cmt_cpu_model_inst.wr(ctl, 8'h66);
    repeat (40) @(posedge ref_clk);
    #1;
    rdc(sts, 8'ha5, "split flags");
    chk("irq hi count", 16'h1, irq_hi_seen[15:0]);
    chk("irq lo count", 16'h1, irq_lo_seen[15:0]);
    chk("pin lo toggled", 16'h1, {15'h0, toggle_pin_lo_r});
    v16 = 16'($urandom);
    cmt_cpu_model_inst.wr(cmp_lo, v16[7:0]);
    cmt_cpu_model_inst.wr(cmp_hi, v16[15:8]);
    rdc(cmp_lo, v16[7:0], "split compare lo");
    rdc(cmp_hi, v16[15:8], "split compare hi");
    cmt_cpu_model_inst.wr(sts, 8'h00);
    $display("test split mode done");

    for (int i = 0; i < 8; i++) begin
      cmt_cpu_model_inst.wr(stp, stop_t[i][7:0]);
      cmt_cpu_model_inst.wr(ctl, 8'h44 | sel_t[i][7:0]);
      cmt_cpu_model_inst.wr(cnt_lo, 8'h00);
      power_mode = mode_t[i][2:0];
      repeat (256) @(posedge ref_clk);
      cmt_cpu_model_inst.rd(cnt_lo, rv);
      power_mode = `CMT_MODE_ACTIVE;
      checks_done++;
      if (rv !== exp_t[i][7:0] && (exp_t[i] == 0 || (rv !== exp_t[i][7:0] + 8'h1 && rv !== exp_t[i][7:0] - 8'h1))) begin
        fail_count++;
        $display("CHECK FAILED rate case %0d expected %h seen %h", i, exp_t[i][7:0], rv);
      end
    end
    power_mode = `CMT_MODE_STANDBY;
    cmt_cpu_model_inst.wr(ctl, 8'h88);
    power_mode = `CMT_MODE_ACTIVE;
    rdc(ctl, 8'h46, "ctrl after standby write");
    $display("test count rates done");
    final_report();
  end
endmodule // testbench
`default_nettype wire
